/* inc/aci_pkg.sv */
// constants shared by both ends of the acquisition interrupt link
// assumes one clock domain; offsets are device word offsets on the link
package aci_pkg;
  // ========================================
  // link and device register map
  localparam int unsigned LINK_AW      = 8;
  localparam int unsigned LINK_DW      = 16;
  localparam logic [7:0]  OFS_STATUS    = 8'h00;
  localparam logic [7:0]  OFS_INT_CTRL  = 8'h02;
  localparam logic [7:0]  OFS_FIFO_PORT = 8'h08;
  localparam logic [7:0]  OFS_UNREAD    = 8'h10;
  localparam int unsigned BIT_DS       = 15;
  localparam int unsigned BIT_FF       = 14;
  localparam int unsigned BIT_HF       = 13;
  localparam int unsigned BIT_RFF      = 3;
  localparam int unsigned BIT_DATA_STORED_IRQ_ENABLE     = 15;
  localparam int unsigned BIT_FULL_IRQ_ENABLE     = 14;
  localparam int unsigned BIT_HALF_FULL_IRQ_ENABLE     = 13;
  localparam int unsigned BIT_DV       = 15;
  localparam int unsigned VAL_LSB      = 4;
  localparam int unsigned FIFO_DEPTH   = 32768;
  localparam int unsigned TS_W         = 31;
  localparam int unsigned VAL_W        = 12;
  localparam logic [15:0] DEV_ZERO     = 16'h0000;
  // ========================================
  // host register map (axi4-lite byte offsets)
  localparam int unsigned AXI_AW       = 8;
  localparam logic [7:0]  HOF_ADDR     = 8'h00;
  localparam logic [7:0]  HOF_WDATA    = 8'h04;
  localparam logic [7:0]  HOF_GO       = 8'h08;
  localparam logic [7:0]  HOF_RDATA    = 8'h0C;
  localparam logic [7:0]  HOF_ISTAT    = 8'h10;
  localparam logic [7:0]  HOF_IMASK    = 8'h14;
  localparam logic [7:0]  HOF_LINK     = 8'h18;
  localparam int unsigned GO_START     = 0;
  localparam int unsigned GO_WRITE     = 1;
  localparam int unsigned EV_DONE      = 0;
  localparam int unsigned EV_DEV       = 1;
  localparam int unsigned EV_N         = 2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [31:0] AXI_ZERO     = 32'h0000_0000;
  // ========================================
  // states
  typedef enum logic [1:0] {WORD_HI, WORD_LO, WORD_VAL} aci_word_e;
  typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_WAIT} aci_hst_e;
endpackage : aci_pkg

/* inc/aci_link_if.sv */
// register link between the carrier host and the acquisition device
// assumes one shared clock; req is a one-cycle pulse, ack answers it
interface aci_link_if
  import aci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b
);
  logic                req;
  logic                we;
  logic [LINK_AW-1:0]  addr;
  logic [LINK_DW-1:0]  wdata;
  logic [LINK_DW-1:0]  rdata;
  logic                ack;
  logic                irq_b;

  modport dev  (input req, we, addr, wdata, output rdata, ack, irq_b);
  modport host (output req, we, addr, wdata, input rdata, ack, irq_b);
endinterface : aci_link_if

/* design/aci_dev.sv */
// acquisition device end: sample fifo, status flags and interrupt request
// assumes the host issues one link access at a time and waits for ack
//
// What this block does
// - request line released by register access
// - three maskable sources: stored, half, full
// - stored flag high while fifo holds data
// - stored request needs its enable set
// - writing one to stored bit releases it
// - half flag follows occupancy at half capacity
// - half request needs its enable set
// - writing one to half bit releases it
// - full flag sticky until fifo reset written
// - full request needs its enable set
// - writing one to full bit releases it
// - enables at offset two, bits 15-13
// - read port valid while unread pairs remain
module aci_dev
  import aci_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  aci_link_if.dev               link,
  input  wire logic             store_valid,
  input  wire logic [TS_W-1:0]  store_time,
  input  wire logic [VAL_W-1:0] store_value,
  output logic                  store_ready,
  output logic                  data_stored_flag,
  output logic                  fifo_half_full_flag,
  output logic                  fifo_full_flag,
  output logic                  read_port_valid
);
  // ========================================
  // sizes and state
  localparam int unsigned AW   = $clog2(DEPTH);
  localparam int unsigned CW   = $clog2(DEPTH + 1);
  localparam int unsigned EW   = TS_W + VAL_W;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);

  typedef struct packed {
    logic [CW-1:0]      count;
    logic [AW-1:0]      wptr;
    logic [AW-1:0]      rptr;
    aci_word_e          word;
    logic               data_stored_irq_enable;
    logic               half_full_irq_enable;
    logic               full_irq_enable;
    logic               ds_pend;
    logic               hf_pend;
    logic               ff_pend;
    logic               half;
    logic               full;
    logic [LINK_DW-1:0] rdata;
    logic               ack;
    logic               irq_b;
  } aci_dev_s;

  aci_dev_s       q;
  aci_dev_s       d;
  logic [EW-1:0]  mem [DEPTH];
  logic [EW-1:0]  head;
  logic           push;
  logic           pop;
  logic           wr_acc;
  logic           rd_acc;
  logic           fifo_rst;
  logic           dv;
  logic [15:0]    rd;

  assign head = mem[q.rptr];
  assign dv   = (q.count != '0);

  // ========================================
  // next state
  always_comb begin
    d        = q;
    pop      = 1'b0;
    rd       = DEV_ZERO;
    wr_acc   = link.req && link.we;
    rd_acc   = link.req && !link.we;
    fifo_rst = wr_acc && (link.addr == OFS_STATUS) && link.wdata[BIT_RFF];
    // stores are refused while full or in a fifo reset write; a pop frees room for the next store
    store_ready = (q.count != FULL_CNT) && !fifo_rst;
    push        = store_valid && store_ready;

    if (rd_acc) begin
      if (link.addr == OFS_STATUS) begin
        rd[BIT_DS] = dv;
        rd[BIT_FF] = q.full;
        rd[BIT_HF] = q.half;
      end else if (link.addr == OFS_INT_CTRL) begin
        rd[BIT_DATA_STORED_IRQ_ENABLE] = q.data_stored_irq_enable;
        rd[BIT_FULL_IRQ_ENABLE] = q.full_irq_enable;
        rd[BIT_HALF_FULL_IRQ_ENABLE] = q.half_full_irq_enable;
      end else if (link.addr == OFS_FIFO_PORT) begin
        // three-word walk; an empty fifo keeps answering the first word
        case (q.word)
          WORD_HI: begin
            rd[BIT_DV]          = dv;
            rd[BIT_DV-1:0]      = head[EW-1 -: 15];
            if (dv) begin
              d.word = WORD_LO;
            end
          end
          WORD_LO: begin
            rd     = head[VAL_W +: 16];
            d.word = WORD_VAL;
          end
          default: begin
            rd[VAL_LSB +: VAL_W] = head[VAL_W-1:0];
            pop    = 1'b1;
            d.word = WORD_HI;
          end
        endcase
      end else if (link.addr == OFS_UNREAD) begin
        rd = 16'(q.count);
      end
    end

    // occupancy
    case ({push, pop})
      2'b10:   d.count = q.count + CNT_ONE;
      2'b01:   d.count = q.count - CNT_ONE;
      default: d.count = q.count;
    endcase
    if (push) begin
      d.wptr = q.wptr + PTR_ONE;
    end
    if (pop) begin
      d.rptr = q.rptr + PTR_ONE;
    end
    if (fifo_rst) begin
      d.count = '0;
      d.wptr  = '0;
      d.rptr  = '0;
      d.word  = WORD_HI;
    end

    d.half = (d.count >= HALF_CNT);
    if (fifo_rst) begin
      d.full = 1'b0;
    end else if (d.count == FULL_CNT) begin
      d.full = 1'b1;
    end

    if (wr_acc && (link.addr == OFS_INT_CTRL)) begin
      d.data_stored_irq_enable = link.wdata[BIT_DATA_STORED_IRQ_ENABLE];
      d.full_irq_enable = link.wdata[BIT_FULL_IRQ_ENABLE];
      d.half_full_irq_enable = link.wdata[BIT_HALF_FULL_IRQ_ENABLE];
    end

    // pending events: a new event in the release cycle survives it
    d.ds_pend = push
      || (q.ds_pend && !(wr_acc && (link.addr == OFS_STATUS)
      && link.wdata[BIT_DS]));
    d.hf_pend = (d.half && !q.half)
      || (q.hf_pend && !(wr_acc && (link.addr == OFS_STATUS)
      && link.wdata[BIT_HF]));
    d.ff_pend = (d.full && !q.full)
      || (q.ff_pend && !(wr_acc && (link.addr == OFS_STATUS)
      && link.wdata[BIT_FF]));

    // three gated sources onto one low-active line
    d.irq_b = !((d.ds_pend && d.data_stored_irq_enable)
             || (d.hf_pend && d.half_full_irq_enable)
             || (d.ff_pend && d.full_irq_enable));

    d.ack   = link.req;
    d.rdata = rd;
  end

  // ========================================
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q       <= '0;
      q.word  <= WORD_HI;
      q.irq_b <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // storage kept out of the reset struct; contents are don't-care until written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wptr] <= {store_time, store_value};
    end
  end

  // ========================================
  // outputs
  assign link.rdata          = q.rdata;
  assign link.ack            = q.ack;
  assign link.irq_b          = q.irq_b;
  assign data_stored_flag    = dv;
  assign read_port_valid     = dv;
  assign fifo_half_full_flag = q.half;
  assign fifo_full_flag      = q.full;
endmodule : aci_dev

/* design/aci_host.sv */
// carrier host end: axi4-lite register slave that runs link accesses
// assumes software writes ADDR and WDATA, then GO, and polls or waits irq
module aci_host
  import aci_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  aci_link_if.host               link,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq
);
  typedef struct packed {
    aci_hst_e           st;
    logic [LINK_AW-1:0] addr;
    logic [LINK_DW-1:0] wdata;
    logic               we;
    logic [LINK_DW-1:0] rdata;
    logic [EV_N-1:0]    istat;
    logic [EV_N-1:0]    imask;
    logic               line_q;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdat;
    logic               irq;
  } aci_host_s;

  aci_host_s q;
  aci_host_s d;
  logic      wr_go;
  logic      rd_go;
  logic      w0;
  logic      w1;
  logic [EV_N-1:0] ev_set;
  logic [EV_N-1:0] ev_clr;

  // ========================================
  // next state
  always_comb begin
    d      = q;
    wr_go  = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    rd_go  = s_axi_arvalid && !q.rvalid;
    w0     = s_axi_wstrb[0];
    w1     = s_axi_wstrb[1];
    ev_set = '0;
    ev_clr = '0;

    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (s_axi_awaddr == HOF_ADDR) begin
        if (w0) d.addr = s_axi_wdata[LINK_AW-1:0];
      end else if (s_axi_awaddr == HOF_WDATA) begin
        if (w0) d.wdata[7:0]  = s_axi_wdata[7:0];
        if (w1) d.wdata[15:8] = s_axi_wdata[15:8];
      end else if (s_axi_awaddr == HOF_GO) begin
        // a start while busy is dropped; software sees busy in GO
        if (w0 && s_axi_wdata[GO_START] && (q.st == HS_IDLE)) begin
          d.we = s_axi_wdata[GO_WRITE];
          d.st = HS_REQ;
        end
      end else if (s_axi_awaddr == HOF_ISTAT) begin
        if (w0) ev_clr = s_axi_wdata[EV_N-1:0];
      end else if (s_axi_awaddr == HOF_IMASK) begin
        if (w0) d.imask = s_axi_wdata[EV_N-1:0];
      end else if (s_axi_awaddr != HOF_RDATA && s_axi_awaddr != HOF_LINK) begin
        d.bresp = RESP_SLVERR;
      end
    end

    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdat   = AXI_ZERO;
      if (s_axi_araddr == HOF_ADDR) begin
        d.rdat[LINK_AW-1:0] = q.addr;
      end else if (s_axi_araddr == HOF_WDATA) begin
        d.rdat[LINK_DW-1:0] = q.wdata;
      end else if (s_axi_araddr == HOF_GO) begin
        d.rdat[GO_START] = (q.st != HS_IDLE);
        d.rdat[GO_WRITE] = q.we;
      end else if (s_axi_araddr == HOF_RDATA) begin
        d.rdat[LINK_DW-1:0] = q.rdata;
      end else if (s_axi_araddr == HOF_ISTAT) begin
        d.rdat[EV_N-1:0] = q.istat;
      end else if (s_axi_araddr == HOF_IMASK) begin
        d.rdat[EV_N-1:0] = q.imask;
      end else if (s_axi_araddr == HOF_LINK) begin
        d.rdat[0] = !link.irq_b;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end

    // link access sequencer; the device answers one cycle after req
    case (q.st)
      HS_REQ: begin
        d.st = HS_WAIT;
      end
      HS_WAIT: begin
        if (link.ack) begin
          d.rdata        = link.rdata;
          ev_set[EV_DONE] = 1'b1;
          d.st           = HS_IDLE;
        end
      end
      HS_IDLE: begin
        // hold: a start taken by the GO write above must survive this case
      end
      default: begin
        d.st = HS_IDLE;
      end
    endcase

    // device request line going active is an event; releasing it is the
    // device's job after the status write-one
    d.line_q       = !link.irq_b;
    ev_set[EV_DEV] = !link.irq_b && !q.line_q;
    d.istat        = ev_set | (q.istat & ~ev_clr);
    d.irq          = |(d.istat & d.imask);
  end

  // ========================================
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q    <= '0;
      q.st <= HS_IDLE;
    end else begin
      q <= d;
    end
  end

  // ========================================
  // outputs
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdat;
  assign irq           = q.irq;
  assign link.req      = (q.st == HS_REQ);
  assign link.we       = q.we;
  assign link.addr     = q.addr;
  assign link.wdata    = q.wdata;
endmodule : aci_host

/* testbench/aci_link_asserts.sv */
// link checker: watches the link signals between host end and device end
// assumes one clock domain and an asynchronous active-low reset
module aci_link_asserts
  import aci_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               req,
  input wire logic               we,
  input wire logic [LINK_AW-1:0] addr,
  input wire logic [LINK_DW-1:0] wdata,
  input wire logic [LINK_DW-1:0] rdata,
  input wire logic               ack,
  input wire logic               irq_b
);
  // ========================================
  // shadow of the enables as last written on the link
  logic [2:0] en_q;
  logic [2:0] en_d;
  always_comb begin
    en_d = en_q;
    if (req && we && addr == OFS_INT_CTRL) begin
      en_d = wdata[15:13];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 3'h0;
    end else begin
      en_q <= en_d;
    end
  end
  // ========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_ACK_NEXT: assert property (req |=> ack)
    else $error("ack missing one cycle after req");
  AST_ACK_CAUSE: assert property (ack |-> $past(req))
    else $error("ack without req");
  AST_REQ_PULSE: assert property (req |=> !req)
    else $error("req longer than one cycle");
  AST_WR_RDATA: assert property (ack && $past(we) |-> rdata == DEV_ZERO)
    else $error("rdata not zero on write ack");
  // one cycle of slack: the request register may lag the enable write
  AST_NO_EN_QUIET: assert property (en_q == 3'h0 && $past(en_q) == 3'h0 |-> irq_b)
    else $error("request with all enables off");
  AST_FALL_NEEDS_EN: assert property ($fell(irq_b) |-> en_q != 3'h0)
    else $error("request raised with no enable set");
  AST_CTRL_READ: assert property (
    ack && !$past(we) && $past(addr) == OFS_INT_CTRL |-> rdata == {en_q, 13'h0000})
    else $error("int ctrl readback wrong");
  AST_STAT_SPARE: assert property (
    ack && !$past(we) && $past(addr) == OFS_STATUS |-> rdata[12:0] == 13'h0000)
    else $error("status spare bits not zero");
endmodule : aci_link_asserts

/* testbench/tb.sv */
// bench: host end and device end joined by the link, software side over axi4-lite
// assumes DEPTH of 8 so half and full are reached in a few stores
module tb
  import aci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 8;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, store_valid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq, store_ready;
  logic        data_stored_flag, fifo_half_full_flag, fifo_full_flag, read_port_valid;
  logic [30:0] st_time;
  logic [11:0] st_val;
  logic [4:0]  rdy;
  wire logic   irq_b;
  int          mismatches, check_count, in_n, out_n;
  assign rdy = {store_ready, rvalid, arready, bvalid, awready && wready};
  aci_link_if u_aci_link_if (.clk(clk), .rst_b(rst_b));
  assign irq_b = u_aci_link_if.irq_b;
  aci_dev #(.DEPTH(DEPTH)) u_aci_dev (.clk(clk), .rst_b(rst_b), .link(u_aci_link_if.dev),
    .store_valid(store_valid), .store_time(st_time), .store_value(st_val),
    .store_ready(store_ready), .data_stored_flag(data_stored_flag),
    .fifo_half_full_flag(fifo_half_full_flag), .fifo_full_flag(fifo_full_flag),
    .read_port_valid(read_port_valid));
  aci_host u_aci_host (.clk(clk), .rst_b(rst_b), .link(u_aci_link_if.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  aci_link_asserts u_aci_link_asserts (.clk(clk), .rst_b(rst_b), .req(u_aci_link_if.req),
    .we(u_aci_link_if.we), .addr(u_aci_link_if.addr), .wdata(u_aci_link_if.wdata),
    .rdata(u_aci_link_if.rdata), .ack(u_aci_link_if.ack), .irq_b(u_aci_link_if.irq_b));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ========================================
  // common tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // ready is judged at the falling edge, taken at the next rising edge
  task automatic wait_for(input int sel);
    do begin
      @(negedge clk);
    end while (rdy[sel] !== 1'b1);
    chk("handshake", 1'b1, rdy[sel]);
    @(posedge clk);
  endtask : wait_for
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    wait_for(0);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    wait_for(1);
    chk("bresp", RESP_OKAY, bresp);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    wait_for(2);
    arvalid <= 1'b0;
    wait_for(3);
    d = rdata;
    r = rresp;
  endtask : axi_read
  task automatic dev_acc(input logic w, input logic [7:0] ofs, input logic [15:0] wd,
                         output logic [15:0] rd);
    logic [31:0] v;
    logic [1:0]  r;
    axi_write(HOF_ADDR, {24'h00_0000, ofs});
    axi_write(HOF_WDATA, {16'h0000, wd});
    axi_write(HOF_GO, {30'h0000_0000, w, 1'b1});
    do begin
      axi_read(HOF_GO, v, r);
    end while (v[0] !== 1'b0);
    axi_read(HOF_RDATA, v, r);
    rd = v[15:0];
  endtask : dev_acc
  task automatic store(input int n);
    st_time     <= {15'h5A5A, 16'(n)};
    st_val      <= 12'hA5C ^ 12'(n);
    store_valid <= 1'b1;
    wait_for(4);
    store_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : store
  task automatic pop_chk(input int n);
    logic [15:0] d;
    dev_acc(1'b0, OFS_FIFO_PORT, 16'h0000, d);
    chk("word1", 32'h0000_DA5A, d);
    dev_acc(1'b0, OFS_FIFO_PORT, 16'h0000, d);
    chk("word2", 16'(n), d);
    dev_acc(1'b0, OFS_FIFO_PORT, 16'h0000, d);
    chk("word3", {12'hA5C ^ 12'(n), 4'h0}, d);
  endtask : pop_chk
  // ========================================
  // scenarios
  task automatic t_reset();
    logic [15:0] d;
    logic [31:0] v;
    logic [1:0]  r;
    chk("irq_b", 1'b1, irq_b);
    chk("flags", 4'h0,
        {data_stored_flag, fifo_half_full_flag, fifo_full_flag, read_port_valid});
    dev_acc(1'b0, OFS_INT_CTRL, 16'h0000, d);
    chk("int_ctrl", 16'h0000, d);
    dev_acc(1'b1, OFS_INT_CTRL, 16'hE000, d);
    dev_acc(1'b0, OFS_INT_CTRL, 16'h0000, d);
    chk("int_ctrl", 16'hE000, d);
    chk("irq_b", 1'b1, irq_b);
    dev_acc(1'b0, 8'h04, 16'h0000, d);
    chk("unmapped", 16'h0000, d);
    axi_read(8'h1C, v, r);
    chk("rresp", RESP_SLVERR, r);
  endtask : t_reset
  task automatic t_stored();
    logic [15:0] d;
    logic [31:0] v;
    logic [1:0]  r;
    dev_acc(1'b1, OFS_INT_CTRL, 16'h0000, d);
    store(in_n++);
    chk("irq_b", 1'b1, irq_b);
    chk("stored", 2'h3, {data_stored_flag, read_port_valid});
    dev_acc(1'b1, OFS_INT_CTRL, 16'h8000, d);
    chk("irq_b", 1'b0, irq_b);
    dev_acc(1'b1, OFS_STATUS, 16'h8000, d);
    chk("irq_b", 1'b1, irq_b);
    chk("stored", 1'b1, data_stored_flag);
    store(in_n++);
    chk("irq_b", 1'b0, irq_b);
    axi_read(HOF_LINK, v, r);
    chk("link", 32'h0000_0001, v);
    axi_write(HOF_IMASK, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("irq", 1'b1, irq);
    axi_write(HOF_IMASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irq", 1'b0, irq);
    axi_write(HOF_ISTAT, 32'h0000_0003);
    dev_acc(1'b0, OFS_STATUS, 16'h0000, d);
    chk("status", 16'h8000, d);
    dev_acc(1'b1, OFS_STATUS, 16'hE000, d);
    chk("irq_b", 1'b1, irq_b);
    pop_chk(out_n++);
    pop_chk(out_n++);
    dev_acc(1'b0, OFS_FIFO_PORT, 16'h0000, d);
    chk("valid", 1'b0, d[15]);
    chk("stored", 2'h0, {data_stored_flag, read_port_valid});
  endtask : t_stored
  task automatic t_half();
    logic [15:0] d;
    dev_acc(1'b1, OFS_INT_CTRL, 16'h2000, d);
    for (int k = 0; k < DEPTH / 2 - 1; k++) begin
      store(in_n++);
    end
    chk("half", 2'h1, {fifo_half_full_flag, irq_b});
    store(in_n++);
    chk("half", 2'h2, {fifo_half_full_flag, irq_b});
    dev_acc(1'b1, OFS_STATUS, 16'h2000, d);
    chk("half", 2'h3, {fifo_half_full_flag, irq_b});
    pop_chk(out_n++);
    chk("half", 1'b0, fifo_half_full_flag);
  endtask : t_half
  task automatic t_full();
    logic [15:0] d;
    dev_acc(1'b1, OFS_INT_CTRL, 16'h4000, d);
    for (int k = 0; k < DEPTH - 3; k++) begin
      store(in_n++);
    end
    chk("full", 2'h2, {fifo_full_flag, irq_b});
    @(negedge clk);
    chk("store_ready", 1'b0, store_ready);
    @(posedge clk);
    dev_acc(1'b1, OFS_STATUS, 16'h0000, d);
    chk("irq_b", 1'b0, irq_b);
    dev_acc(1'b1, OFS_STATUS, 16'h4000, d);
    chk("irq_b", 1'b1, irq_b);
    pop_chk(out_n++);
    chk("full", 1'b1, fifo_full_flag);
    dev_acc(1'b0, OFS_UNREAD, 16'h0000, d);
    chk("unread", DEPTH - 1, d);
    dev_acc(1'b0, OFS_STATUS, 16'h0000, d);
    chk("status", 16'hE000, d);
    dev_acc(1'b1, OFS_STATUS, 16'h0008, d);
    chk("cleared", 3'h0, {fifo_full_flag, data_stored_flag, read_port_valid});
  endtask : t_full
  // ========================================
  // run control
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    rst_b       = 1'b0;
    {awvalid, wvalid, arvalid, store_valid} = 4'h0;
    {awaddr, araddr, wdata, st_time, st_val} = '0;
    // both answers are always taken at once
    bready      = 1'b1;
    rready      = 1'b1;
    wstrb       = 4'hF;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_stored();
    t_half();
    t_full();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : tb
